// ### dv/ccig_far_model.sv
`timescale 1ns/1ps
// ********************
// Oscillator, PLL and USB bus side
// ********************
module ccig_far_model #(
    parameter int WARM = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Oscillator control and bus traffic
    input wire logic osc_enable,
    input wire logic bus_busy,
    output logic clk_stable,
    output logic bus_activity
);
    int warm_cnt;

    // Settling count restarts whenever the oscillator is stopped
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            warm_cnt <= 0;
        end else if (!osc_enable) begin
            warm_cnt <= 0;
        end else if (warm_cnt < WARM) begin
            warm_cnt <= warm_cnt + 1;
        end
    end

    // Stable only after a real warm-up, so early signalling shows up
    assign clk_stable = osc_enable && (warm_cnt >= WARM);
    assign bus_activity = bus_busy;
endmodule : ccig_far_model

// ### dv/cpu_core_integration_glue_tb.sv
`timescale 1ns/1ps
module cpu_core_integration_glue_tb import ccig_pkg::*; ;
    // ********************
    // Signals
    // ********************
    logic ref_clk, rst_n, sfr_ack, movx_req, movx_indirect, movx_wr, movx_ext, bus_phase_end;
    ccig_sfr_s sfr;
    ccig_strb_s mem_strb;
    logic [7:0] sfr_rdata, movx_rptr, code_byte, fetch_byte, d, sus, page_val;
    logic [15:0] movx_dptr, mem_addr;
    logic [7:0] pin_in, io_latch, io_oe, io_alt, alt_out, alt_oe, pin_out, pin_oe, io_level;
    logic [12:0] irq_v, cpu_irq;
    logic [20:0] usb_src;
    logic vec_insert_en, vector_fetch, bus_busy, bus_activity, wake_pin_n, clk_stable, isr_done;
    logic osc_enable, cpu_halt, remote_wakeup, resume_wake_irq, suspend_ctrl;
    logic [1:0] cs_arr;
    logic [31:0] seed;
    logic [7:0] legacy [4] = '{SFR_LEGACY_PORT_A, SFR_LEGACY_PORT_B, SFR_LEGACY_PORT_C, SFR_LEGACY_PORT_D};
    int bad_count, check_count, n;

    // Short counts keep the idle and warm-up waits cheap
    ccig_glue #(.PIN_COUNT(8), .IDLE_CYCLES(20), .STABLE_CYCLES(4)) uut (
        .ref_clk, .rst_n, .sfr, .sfr_rdata, .sfr_ack, .movx_req, .movx_indirect, .movx_wr, .movx_dptr,
        .movx_rptr, .movx_ext, .mem_addr, .mem_strb, .bus_phase_end, .pin_in, .io_latch, .io_oe, .io_alt,
        .alt_out, .alt_oe, .pin_out, .pin_oe, .io_level, .ext_pin_irq_a_n(~irq_v[0]), .ext_pin_irq_b_n(~irq_v[1]),
        .timer0_irq(irq_v[2]), .timer1_irq(irq_v[3]), .serial_port_a_irq(irq_v[4]), .two_wire_ctrl_irq(irq_v[6]),
        .pin_irq_four(irq_v[7]), .pin_irq_five_n(~irq_v[8]), .pin_irq_six(irq_v[9]), .serial_port_b_irq(irq_v[11]),
        .third_timer_irq(irq_v[12]), .usb_src, .vec_insert_en, .vector_fetch, .code_byte, .cpu_irq, .fetch_byte,
        .bus_activity, .wake_pin_n, .clk_stable, .isr_done, .osc_enable, .cpu_halt, .remote_wakeup,
        .resume_wake_irq, .suspend_ctrl
    );
    ccig_far_model #(.WARM(3)) far (.ref_clk, .rst_n, .osc_enable, .bus_busy, .clk_stable, .bus_activity);

    // 100 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ********************
    // Helpers
    // ********************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr

    // Lowest pending source wins, byte is index times step
    function automatic logic [7:0] vec_exp(input logic [20:0] s);
        for (int k = 0; k < 21; k++) begin
            if (s[k]) return 8'(k * VEC_STEP);
        end
        return 8'h00;
    endfunction : vec_exp

    function automatic logic sig(input int s);
        case (s)
            0: return cpu_halt;
            1: return osc_enable;
            2: return resume_wake_irq;
            3: return cpu_irq[5];
            default: return remote_wakeup;
        endcase
    endfunction : sig

    task automatic tick(input int k = 1);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic report_and_stop;
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Bounded wait; running out ends the run
    task automatic wait_sig(input string what, input int s, input logic v, input int lim);
        for (int k = 0; k < lim && sig(s) !== v; k++) begin
            tick();
        end
        check_count++;
        if (sig(s) !== v) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, v, sig(s));
            report_and_stop();
        end
    endtask : wait_sig

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
        sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        tick();
        sfr = '0;
        tick();
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
        sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        tick();
        chk("sfr_ack", 1, sfr_ack);
        v = sfr_rdata;
        sfr = '0;
        tick();
    endtask : sfr_rd

    // Request held until well past the capturing phase
    task automatic movx(input logic ind, input logic wr, input logic ext, input logic [7:0] pg);
        logic [15:0] exp;
        seed = lfsr(seed);
        movx_indirect = ind;
        movx_wr = wr;
        movx_ext = ext;
        movx_dptr = seed[15:0];
        movx_rptr = seed[23:16];
        movx_req = 1'b1;
        exp = ind ? {pg, seed[23:16]} : seed[15:0];
        tick(6);
        chk("mem_addr", exp, mem_addr);
        chk("strb_dir", {wr, !wr}, {mem_strb.rd_n, mem_strb.wr_n});
        chk("strb_sel", {!ext, !(ext && !wr)}, {mem_strb.cs_n, mem_strb.oe_n});
        cs_arr[ext] = mem_strb.cs_n;
        movx_req = 1'b0;
        tick(4);
    endtask : movx

    // ********************
    // Main sequence
    // ********************
    initial begin
        rst_n = 1'b0;
        seed = 32'h88e1;
        sfr = '0;
        {movx_req, movx_indirect, movx_wr, movx_ext, movx_dptr, movx_rptr} = '0;
        {pin_in, io_latch, io_oe, io_alt, alt_out, alt_oe} = '0;
        {irq_v, usb_src, vec_insert_en, vector_fetch, code_byte, isr_done} = '0;
        bus_busy = 1'b1;
        wake_pin_n = 1'b1;
        sus = 8'(1 << SUSPEND_BIT_POS);
        bad_count = 0;
        check_count = 0;
        tick(16);
        chk("rst_out", 6'h2f, {osc_enable, cpu_halt, mem_strb});
        rst_n = 1'b1;
        tick(2);
        sfr_rd(SFR_PAGE, d);
        chk("page_rst", PAGE_RESET, d);
        // Page register survives writes to the dropped port addresses
        repeat (4) begin
            seed = lfsr(seed);
            sfr_wr(SFR_PAGE, seed[7:0]);
            for (int j = 0; j < 4; j++) sfr_wr(legacy[j], ~seed[7:0]);
            sfr_rd(legacy[seed[1:0]], d);
            chk("legacy_rd", 8'h00, d);
            sfr_rd(SFR_PAGE, d);
            chk("page", seed[7:0], d);
        end
        // Bus cycle length between phase pulses
        for (n = 0; n < 8 && bus_phase_end !== 1'b1; n++) tick();
        n = 0;
        do begin
            tick();
            n++;
        end while (bus_phase_end !== 1'b1 && n < 12);
        chk("phase_len", BUS_CYCLE_CLOCKS, n);
        // Every mix of pointer kind, direction and space
        page_val = seed[7:0];
        for (int i = 0; i < 8; i++) begin
            movx(i[2], i[1], i[0], page_val);
            if (i[0]) chk("cs_sep", 1, cs_arr[0] !== cs_arr[1]);
        end
        // Pin resources under random configuration
        repeat (6) begin
            seed = lfsr(seed);
            {pin_in, io_latch, io_oe, io_alt} = seed;
            seed = lfsr(seed);
            {alt_out, alt_oe} = seed[15:0];
            tick(2);
            chk("pin_out", (io_alt & alt_out) | (~io_alt & io_latch), pin_out);
            chk("pin_oe", (io_alt & alt_oe) | (~io_alt & io_oe), pin_oe);
            chk("io_level", pin_in, io_level);
        end
        // Each non-USB input source lands on its own request line; the resume line 10 is not driven here
        for (int i = 0; i < 13; i++) begin
            if (i == 5 || i == 10) continue;
            irq_v = 13'h1 << i;
            tick(2);
            chk("cpu_irq", irq_v, cpu_irq);
        end
        irq_v = '0;
        vec_insert_en = 1'b1;
        vector_fetch = 1'b1;
        for (int i = 0; i < 21; i++) begin
            seed = lfsr(seed);
            usb_src = (21'h1 << i) | (seed[20:0] & ~((21'h2 << i) - 21'h1));
            code_byte = seed[31:24];
            tick(2);
            chk("fetch_byte", vec_exp(usb_src), fetch_byte);
            chk("usb_irq", 1, cpu_irq[5]);
        end
        vec_insert_en = 1'b0;
        tick(2);
        chk("fetch_raw", code_byte, fetch_byte);
        usb_src = '0;
        vector_fetch = 1'b0;
        tick(2);
        chk("usb_irq_quiet", 0, cpu_irq[5]);
        // Suspend, blocked by wake pin, then woken by bus traffic
        bus_busy = 1'b0;
        wait_sig("idle_irq", 3, 1, 40);
        wake_pin_n = 1'b0;
        sfr_wr(SFR_POWER_CTRL, sus);
        tick(6);
        chk("halt_blocked", 0, cpu_halt);
        wake_pin_n = 1'b1;
        wait_sig("halt", 0, 1, 20);
        chk("suspend_ctrl", 1, suspend_ctrl);
        wait_sig("osc_off", 1, 0, 4);
        movx_req = 1'b1;
        tick(8);
        chk("strb_halted", 2'b11, {mem_strb.rd_n, mem_strb.wr_n});
        movx_req = 1'b0;
        bus_busy = 1'b1;
        wait_sig("osc_on", 1, 1, 20);
        wait_sig("resume_irq", 2, 1, 40);
        chk("stable_first", 1, clk_stable);
        tick();
        chk("resume_line", 1, cpu_irq[10]);
        isr_done = 1'b1;
        tick();
        isr_done = 1'b0;
        wait_sig("run", 0, 0, 10);
        // Second suspend, woken by the wake pin edge
        bus_busy = 1'b0;
        sfr_wr(SFR_POWER_CTRL, sus);
        wait_sig("halt2", 0, 1, 20);
        wait_sig("osc_off2", 1, 0, 4);
        wake_pin_n = 1'b0;
        wait_sig("remote_wake", 4, 1, 20);
        wait_sig("osc_on2", 1, 1, 20);
        wait_sig("resume_irq2", 2, 1, 40);
        isr_done = 1'b1;
        tick();
        isr_done = 1'b0;
        wake_pin_n = 1'b1;
        bus_busy = 1'b1;
        wait_sig("run2", 0, 0, 10);
        tick(4);
        report_and_stop();
    end
endmodule : cpu_core_integration_glue_tb

// ### src/ccig_glue.sv
// Function
// - Standard instruction set stays unchanged
// - Bus cycle lasts four clocks, not twelve
// - Processor core clocked at 24 MHz
// - Register RAM, SFR space, indirect upper bytes
// - On-chip memories reached by external moves
// - Strobes separate internal and external spaces
// - Legacy port SFRs not implemented
// - Page register gives upper indirect address
// - Each pin: latch, level, output enable
// - Each pin: alternate function select bit
// - Standard interrupts all kept
// - Added interrupt sources assigned as listed
// - USB interrupt shared by 21 sources
// - Vector insertion replaces jump low byte
// - Three ms idle raises suspend request
// - Suspend bit halts processor until interrupt
// - Suspend stops oscillator and PLL
// - Wake on bus activity or wake pin
// - Restart clocks, wait stable before signalling
// - Then assert high-priority resume interrupt
// - Resume continues after suspending instruction
// - Wake pin falling edge restarts and interrupts
// - Wake pin low blocks suspend
`timescale 1ns/1ps
module ccig_glue import ccig_pkg::*; #(
    parameter int PIN_COUNT = 8,
    parameter int IDLE_CYCLES = IDLE_SUSPEND_CYCLES,
    parameter int STABLE_CYCLES = CLK_STABLE_CYCLES_DEF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Processor special-function bus
    input wire ccig_sfr_s sfr,
    output logic [7:0] sfr_rdata,
    output logic sfr_ack,
    // Processor external move request
    input wire logic movx_req,
    input wire logic movx_indirect,
    input wire logic movx_wr,
    input wire logic [15:0] movx_dptr,
    input wire logic [7:0] movx_rptr,
    input wire logic movx_ext,
    output logic [15:0] mem_addr,
    output ccig_strb_s mem_strb,
    output logic bus_phase_end,
    // IO pins
    input wire logic [PIN_COUNT-1:0] pin_in,
    input wire logic [PIN_COUNT-1:0] io_latch,
    input wire logic [PIN_COUNT-1:0] io_oe,
    input wire logic [PIN_COUNT-1:0] io_alt,
    input wire logic [PIN_COUNT-1:0] alt_out,
    input wire logic [PIN_COUNT-1:0] alt_oe,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe,
    output logic [PIN_COUNT-1:0] io_level,
    // Interrupt sources
    input wire logic ext_pin_irq_a_n,
    input wire logic ext_pin_irq_b_n,
    input wire logic timer0_irq,
    input wire logic timer1_irq,
    input wire logic serial_port_a_irq,
    input wire logic two_wire_ctrl_irq,
    input wire logic pin_irq_four,
    input wire logic pin_irq_five_n,
    input wire logic pin_irq_six,
    input wire logic serial_port_b_irq,
    input wire logic third_timer_irq,
    input wire logic [USB_SRC_COUNT-1:0] usb_src,
    input wire logic vec_insert_en,
    input wire logic vector_fetch,
    input wire logic [7:0] code_byte,
    output logic [12:0] cpu_irq,
    output logic [7:0] fetch_byte,
    // USB bus and power
    input wire logic bus_activity,
    input wire logic wake_pin_n,
    input wire logic clk_stable,
    input wire logic isr_done,
    output logic osc_enable,
    output logic cpu_halt,
    output logic remote_wakeup,
    output logic resume_wake_irq,
    output logic suspend_ctrl
);

    // ************************************************************
    // Special function registers
    // ************************************************************
    logic [7:0] indirect_page_register;
    logic suspend_request_bit;
    logic [7:0] next_rdata;
    wire page_hit = sfr.addr == SFR_PAGE;
    wire pwr_hit = sfr.addr == SFR_POWER_CTRL;
    // Legacy port addresses decode to nothing and read zero
    wire legacy_hit = sfr.addr == SFR_LEGACY_PORT_A || sfr.addr == SFR_LEGACY_PORT_B ||
                      sfr.addr == SFR_LEGACY_PORT_C || sfr.addr == SFR_LEGACY_PORT_D;
    ccig_pwr_e state;
    ccig_pwr_e next_state;

    // Read mux; RAM and other SFRs live in the core itself
    always_comb begin
        next_rdata = 8'h00;
        if (page_hit) begin
            next_rdata = indirect_page_register;
        end else if (pwr_hit) begin
            next_rdata = {7'h00, suspend_request_bit};
        end else if (legacy_hit) begin
            next_rdata = 8'h00;
        end
    end

    // Register writes; suspend bit drops when the resume routine ends
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            indirect_page_register <= PAGE_RESET;
            suspend_request_bit <= 1'b0;
            sfr_rdata <= 8'h00;
            sfr_ack <= 1'b0;
        end else begin
            sfr_ack <= sfr.wr | sfr.rd;
            sfr_rdata <= next_rdata;
            if (sfr.wr && page_hit) begin
                indirect_page_register <= sfr.wdata;
            end
            if (sfr.wr && pwr_hit && sfr.wdata[SUSPEND_BIT_POS]) begin
                suspend_request_bit <= 1'b1;
            end else if (state == CCIG_RESUME && isr_done) begin
                suspend_request_bit <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Bus cycle timing and memory strobes
    // ************************************************************
    logic [1:0] phase;
    logic movx_busy;
    logic [15:0] next_addr;
    // Indirect moves take the upper byte from the page register
    assign next_addr = movx_indirect ? {indirect_page_register, movx_rptr} : movx_dptr;

    // Four clocks per bus cycle, counter free running so no idle gaps
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 2'd0;
            bus_phase_end <= 1'b0;
            movx_busy <= 1'b0;
            mem_addr <= 16'h0000;
            mem_strb <= '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, oe_n: 1'b1};
        end else begin
            phase <= phase + 2'd1;
            bus_phase_end <= phase == 2'd2;
            if (phase == 2'd3) begin
                movx_busy <= movx_req && !cpu_halt;
                mem_addr <= next_addr;
                // Chip select only for external space, internal RAM uses its own path
                mem_strb.rd_n <= !(movx_req && !movx_wr && !cpu_halt);
                mem_strb.wr_n <= !(movx_req && movx_wr && !cpu_halt);
                mem_strb.cs_n <= !(movx_req && movx_ext && !cpu_halt);
                mem_strb.oe_n <= !(movx_req && !movx_wr && movx_ext && !cpu_halt);
            end
        end
    end

    // ************************************************************
    // IO pins
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
            // Alternate function takes both data and enable
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_out[gi] <= 1'b0;
                    pin_oe[gi] <= 1'b0;
                    io_level[gi] <= 1'b0;
                end else begin
                    pin_out[gi] <= io_alt[gi] ? alt_out[gi] : io_latch[gi];
                    pin_oe[gi] <= io_alt[gi] ? alt_oe[gi] : io_oe[gi];
                    io_level[gi] <= pin_in[gi];
                end
            end
        end
    endgenerate

    // ************************************************************
    // Suspend detection and power sequence
    // ************************************************************
    logic [$clog2(IDLE_CYCLES+1)-1:0] idle_cnt;
    logic [$clog2(STABLE_CYCLES+1)-1:0] warm_cnt;
    logic wake_prev;
    logic usb_suspend_evt;
    wire wake_fall = wake_prev && !wake_pin_n;
    wire idle_done = idle_cnt == ($clog2(IDLE_CYCLES+1))'(IDLE_CYCLES);
    wire warm_done = warm_cnt == ($clog2(STABLE_CYCLES+1))'(STABLE_CYCLES);
    wire wake_evt = bus_activity || wake_fall;

    // Next power state
    always_comb begin
        next_state = state;
        case (state)
            CCIG_RUN: begin
                // Held-low wake pin keeps the chip awake
                if (suspend_request_bit && wake_pin_n) next_state = CCIG_HALTED;
            end
            CCIG_HALTED: next_state = CCIG_OSC_OFF;
            CCIG_OSC_OFF: begin
                if (wake_evt) next_state = CCIG_WARMUP;
            end
            CCIG_WARMUP: begin
                if (warm_done && clk_stable) next_state = CCIG_RESUME;
            end
            CCIG_RESUME: begin
                if (isr_done) next_state = CCIG_RUN;
            end
            default: next_state = CCIG_RUN;
        endcase
    end

    // Sequencer, idle counter and warm-up wait
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= CCIG_RUN;
            idle_cnt <= '0;
            warm_cnt <= '0;
            wake_prev <= 1'b1;
            usb_suspend_evt <= 1'b0;
            osc_enable <= 1'b1;
            cpu_halt <= 1'b0;
            remote_wakeup <= 1'b0;
            resume_wake_irq <= 1'b0;
            suspend_ctrl <= 1'b0;
        end else begin
            state <= next_state;
            wake_prev <= wake_pin_n;
            // Idle count runs only in the run state
            if (bus_activity || state != CCIG_RUN) begin
                idle_cnt <= '0;
            end else if (!idle_done) begin
                idle_cnt <= idle_cnt + 1'b1;
            end
            usb_suspend_evt <= idle_cnt == ($clog2(IDLE_CYCLES+1))'(IDLE_CYCLES - 1);
            warm_cnt <= (state == CCIG_WARMUP && !warm_done) ? warm_cnt + 1'b1 :
                        (state == CCIG_WARMUP ? warm_cnt : '0);
            suspend_ctrl <= next_state == CCIG_HALTED || next_state == CCIG_OSC_OFF;
            osc_enable <= next_state != CCIG_OSC_OFF;
            cpu_halt <= next_state != CCIG_RUN && next_state != CCIG_RESUME;
            resume_wake_irq <= next_state == CCIG_RESUME;
            if (state == CCIG_OSC_OFF && wake_fall) begin
                remote_wakeup <= 1'b1;
            end else if (state == CCIG_RUN) begin
                remote_wakeup <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Interrupt map and vector insertion
    // ************************************************************
    logic [4:0] top_src;
    logic usb_any;
    // Lowest index is highest priority; bytes spaced so each slot fits a jump
    always_comb begin
        top_src = 5'd0;
        for (int i = USB_SRC_COUNT - 1; i >= 0; i--) begin
            if (usb_src[i]) top_src = 5'(i);
        end
    end
    assign usb_any = |usb_src || usb_suspend_evt;

    // Registered interrupt lines in the processor's input order
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_irq <= 13'h0000;
            fetch_byte <= 8'h00;
        end else begin
            cpu_irq <= {third_timer_irq, serial_port_b_irq, resume_wake_irq, pin_irq_six, !pin_irq_five_n,
                        pin_irq_four, two_wire_ctrl_irq, usb_any, serial_port_a_irq, timer1_irq,
                        timer0_irq, !ext_pin_irq_b_n, !ext_pin_irq_a_n};
            fetch_byte <= (vector_fetch && vec_insert_en && |usb_src) ?
                          8'(top_src * VEC_STEP) : code_byte;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_bus_cycle;
        @(posedge ref_clk) disable iff (!rst_n) bus_phase_end |-> ##4 bus_phase_end;
    endproperty
    a_bus_cycle: assert property (p_bus_cycle) else $error("bus cycle not four clocks");

    property p_page;
        @(posedge ref_clk) disable iff (!rst_n) sfr.wr && page_hit |=> indirect_page_register == $past(sfr.wdata);
    endproperty
    a_page: assert property (p_page) else $error("page register not written");

    property p_legacy;
        @(posedge ref_clk) disable iff (!rst_n) sfr.rd && legacy_hit |=> sfr_rdata == 8'h00;
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy port responded");

    property p_no_susp_wake_low;
        @(posedge ref_clk) disable iff (!rst_n) state == CCIG_RUN && !wake_pin_n |=> state != CCIG_HALTED;
    endproperty
    a_no_susp_wake_low: assert property (p_no_susp_wake_low) else $error("suspended with wake low");

    sequence s_halt;
        state == CCIG_HALTED ##1 state == CCIG_OSC_OFF;
    endsequence
    property p_osc_off;
        @(posedge ref_clk) disable iff (!rst_n) s_halt |-> !osc_enable && suspend_ctrl;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator not stopped");

    property p_resume_after_stable;
        @(posedge ref_clk) disable iff (!rst_n) $rose(resume_wake_irq) |-> $past(clk_stable) && osc_enable;
    endproperty
    a_resume_after_stable: assert property (p_resume_after_stable) else $error("resume before stable");

    property p_halted;
        @(posedge ref_clk) disable iff (!rst_n) state == CCIG_OSC_OFF |-> cpu_halt;
    endproperty
    a_halted: assert property (p_halted) else $error("cpu not halted");

    // A halted processor must not start a move at the next bus cycle
    property p_halt_strobe;
        @(posedge ref_clk) disable iff (!rst_n)
            cpu_halt && phase == 2'd3 |=> !movx_busy && mem_strb.rd_n && mem_strb.wr_n && mem_strb.cs_n;
    endproperty
    a_halt_strobe: assert property (p_halt_strobe) else $error("move ran while halted");

    property p_vector;
        @(posedge ref_clk) disable iff (!rst_n)
            vector_fetch && vec_insert_en && usb_src[0] |=> fetch_byte == 8'h00;
    endproperty
    a_vector: assert property (p_vector) else $error("vector byte wrong");

    property p_indirect_addr;
        @(posedge ref_clk) disable iff (!rst_n)
            phase == 2'd3 && movx_req && movx_indirect |=> mem_addr[15:8] == $past(indirect_page_register);
    endproperty
    a_indirect_addr: assert property (p_indirect_addr) else $error("page not used");
endmodule : ccig_glue

// ### src/ccig_pkg.sv
package ccig_pkg;
    // ************************************************************
    // Special function addresses
    // ************************************************************
    localparam logic [7:0] SFR_LEGACY_PORT_A = 8'h80;
    localparam logic [7:0] SFR_LEGACY_PORT_B = 8'h90;
    localparam logic [7:0] SFR_LEGACY_PORT_C = 8'ha0;
    localparam logic [7:0] SFR_LEGACY_PORT_D = 8'hb0;
    localparam logic [7:0] SFR_PAGE = 8'h92;
    localparam logic [7:0] SFR_POWER_CTRL = 8'h87;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam int SUSPEND_BIT_POS = 0;
    localparam int SFR_SPACE_START = 8'h80;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int BUS_CYCLE_CLOCKS = 4;
    localparam int LEGACY_CYCLE_CLOCKS = 12;
    localparam int CORE_CLK_MHZ = 24;
    localparam int IDLE_SUSPEND_MS = 3;
    localparam int IDLE_SUSPEND_CYCLES = IDLE_SUSPEND_MS * (CLK_HZ / 1000);
    localparam int CLK_STABLE_CYCLES_DEF = 16;

    // ************************************************************
    // USB shared interrupt sources and vector bytes
    // ************************************************************
    localparam int USB_SRC_COUNT = 21;
    localparam int BULK_EP_COUNT = 16;
    localparam int VEC_STEP = 4;

    // Power sequence states
    typedef enum logic [2:0] {
        CCIG_RUN = 3'b000,
        CCIG_HALTED = 3'b001,
        CCIG_OSC_OFF = 3'b010,
        CCIG_WARMUP = 3'b011,
        CCIG_RESUME = 3'b100
    } ccig_pwr_e;

    // Processor special-function access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccig_sfr_s;

    // Strobes towards memory
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic cs_n;
        logic oe_n;
    } ccig_strb_s;
endpackage : ccig_pkg
